//--- logic/dac_link_pkg.sv
package dac_link_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int unsigned FRAME_BITS     = 16;
    localparam int unsigned CODE_BITS      = 12;
    localparam int unsigned MODE_HI_POS    = 13;
    localparam int unsigned MODE_LO_POS    = 12;
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [4:0]  COUNT_LAST     = 5'h10;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_PD_1K   = 2'h1,
        MODE_PD_100K = 2'h2,
        MODE_PD_OPEN = 2'h3
    } op_mode_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned MCLK_HZ        = 20_000_000;
    localparam int unsigned MCLK_PERIOD_PS = 1_000_000_000 / (MCLK_HZ / 1000);
    localparam int unsigned SEL_HIGH_MIN_PS = 33_000;
    localparam int unsigned SEL_HIGH_RAW    = (SEL_HIGH_MIN_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int unsigned SEL_HIGH_CYC    = (SEL_HIGH_RAW < 1) ? 1 : SEL_HIGH_RAW;
    localparam int unsigned WAKE_NS         = 2_500;
    localparam int unsigned WAKE_CYC        = (WAKE_NS * (MCLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SCLK_MAX_HZ     = 30_000_000;
    // Host shift clock half period in mclk cycles; 4 gives 2.5 MHz
    localparam int unsigned HALF_PERIOD_CYC = 4;
    localparam logic [7:0]  HALF_PERIOD     = 8'(HALF_PERIOD_CYC);
    localparam logic [7:0]  SEL_HIGH        = 8'(SEL_HIGH_CYC);
    localparam logic [7:0]  WAKE_COUNT      = 8'(WAKE_CYC);
endpackage : dac_link_pkg

//--- logic/dac_link_if.sv
`timescale 1ns/1ps
interface dac_link_if;
    logic frame_sel_n;
    logic shift_clk;
    logic serial_data;

    modport host_end (output frame_sel_n, output shift_clk, output serial_data);
    modport dac_end  (input  frame_sel_n, input  shift_clk, input  serial_data);
endinterface : dac_link_if

//--- logic/dac_load_end.sv
`timescale 1ns/1ps
// Contract
// - Host opens frame with falling select
// - Sample data on falling shift edges
// - Sixteenth edge loads code and mode
// - Host holds select high 33 ns
// - Host may park select low
// - Frame: two ignored, mode, twelve data
// - Host sends MSB first
// - Early select rise discards frame
// - Code clears to zero at reset
// - Mode field decodes four modes
// - Power-down disconnects output, disables analog
// - Power-down keeps the code; here a power-down frame still loads its twelve data bits into dac_code
// - Output valid after wake recovery
// - Code is straight binary
// - Shift clock up to 30 MHz; this end samples it with mclk and tops out near mclk/4
// - Shift register enabled only select low
module dac_load_end
    import dac_link_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    dac_link_if.dac_end      link,
    output logic [11:0]      dac_code,
    output op_mode_t         op_mode,
    output logic             amp_enable,
    output logic             term_1k,
    output logic             term_100k,
    output logic             output_valid,
    output logic             load_pulse
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sel_sync;
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic       clk_prev;
    logic       sel_prev;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sel_sync <= 2'h3;
        end else begin
            sel_sync <= {sel_sync[0], link.frame_sel_n};
        end
    end

    // Each shift phase needs two mclk here, so the link tops out near mclk/4
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clk_sync <= 2'h3;
        end else begin
            clk_sync <= {clk_sync[0], link.shift_clk};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dat_sync <= 2'h0;
        end else begin
            dat_sync <= {dat_sync[0], link.serial_data};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clk_prev <= 1'b1;
            sel_prev <= 1'b1;
        end else begin
            clk_prev <= clk_sync[1];
            sel_prev <= sel_sync[1];
        end
    end

    // Data is read from the same stage as the clock, so setup seen on pins holds
    logic fall_edge;
    logic sel_fall;
    assign fall_edge = clk_prev & ~clk_sync[1];
    assign sel_fall  = sel_prev & ~sel_sync[1];

    // ------------------------------------------------------------
    // Frame shift
    // ------------------------------------------------------------
    logic [15:0] shift;
    logic [4:0]  bit_count;
    logic        armed;
    logic        frame_done;

    assign frame_done = armed && !sel_sync[1] && fall_edge && (bit_count == COUNT_LAST - 5'h1);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            armed <= 1'b0;
        end else if (sel_sync[1]) begin
            armed <= 1'b0;
        end else if (sel_fall) begin
            armed <= 1'b1;
        end else if (frame_done) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shift     <= 16'h0000;
            bit_count <= 5'h00;
        end else if (sel_sync[1] || sel_fall) begin
            shift     <= 16'h0000;
            bit_count <= 5'h00;
        end else if (armed && fall_edge) begin
            shift     <= {shift[14:0], dat_sync[1]};
            bit_count <= bit_count + 5'h01;
        end
    end

    // Last bit joins the word in the same cycle it is sampled
    logic [15:0] full_word;
    assign full_word = {shift[14:0], dat_sync[1]};

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic logic mode_powered_down(input op_mode_t m);
        return (m != MODE_NORMAL);
    endfunction : mode_powered_down

    // Open-output mode selects no termination, leaving the pin floating
    function automatic logic [1:0] mode_termination(input op_mode_t m);
        logic [1:0] sel;
        case (m)
            MODE_PD_1K: begin
                sel = 2'h1;
            end
            MODE_PD_100K: begin
                sel = 2'h2;
            end
            default: begin
                sel = 2'h0;
            end
        endcase
        return sel;
    endfunction : mode_termination

    // ------------------------------------------------------------
    // Code and mode registers
    // ------------------------------------------------------------
    // An aborted frame never raises frame_done, so neither register moves
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dac_code <= CODE_RESET;
        end else if (frame_done) begin
            dac_code <= full_word[CODE_BITS-1:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            op_mode <= MODE_NORMAL;
        end else if (frame_done) begin
            op_mode <= op_mode_t'({full_word[MODE_HI_POS], full_word[MODE_LO_POS]});
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            load_pulse <= 1'b0;
        end else begin
            load_pulse <= frame_done;
        end
    end

    // ------------------------------------------------------------
    // Output stage control
    // ------------------------------------------------------------
    // Code is never touched here: power-down only gates the stage
    logic [1:0] term_sel;
    assign term_sel = mode_termination(op_mode);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            amp_enable <= 1'b1;
            term_1k    <= 1'b0;
            term_100k  <= 1'b0;
        end else begin
            amp_enable <= !mode_powered_down(op_mode);
            term_1k    <= term_sel[0];
            term_100k  <= term_sel[1];
        end
    end

    // ------------------------------------------------------------
    // Wake recovery
    // ------------------------------------------------------------
    // Counter reloads while powered down, so recovery starts at the mode change
    logic [7:0] wake_count;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_count   <= 8'h00;
            output_valid <= 1'b1;
        end else if (mode_powered_down(op_mode)) begin
            wake_count   <= WAKE_COUNT;
            output_valid <= 1'b0;
        end else if (wake_count != 8'h00) begin
            wake_count   <= wake_count - 8'h01;
            output_valid <= (wake_count == 8'h01);
        end else begin
            output_valid <= 1'b1;
        end
    end
endmodule : dac_load_end

//--- logic/dac_host_end.sv
`timescale 1ns/1ps
module dac_host_end
    import dac_link_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        nrst,
    dac_link_if.host_end     link,
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_mode,
    input  wire logic [11:0] req_code,
    input  wire logic        park_low,
    output logic             req_ready,
    output logic             done
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_GAP   = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_END   = 4'b1000
    } host_state_t;

    host_state_t state;
    logic [15:0] word;
    logic [4:0]  sent;
    logic [7:0]  tick;
    logic        parked;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Shift clock idles high; data changes on rising edges, device samples falling
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state             <= ST_IDLE;
            word              <= 16'h0000;
            sent              <= 5'h00;
            tick              <= 8'h00;
            parked            <= 1'b0;
            link.frame_sel_n  <= 1'b1;
            link.shift_clk    <= 1'b1;
            link.serial_data  <= 1'b0;
            req_ready         <= 1'b1;
            done              <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        word             <= {2'h0, req_mode, req_code};
                        parked           <= park_low;
                        link.frame_sel_n <= 1'b1;
                        tick             <= SEL_HIGH;
                        req_ready        <= 1'b0;
                        state            <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tick > 8'h01) begin
                        tick <= tick - 8'h01;
                    end else begin
                        link.frame_sel_n <= 1'b0;
                        link.serial_data <= word[FRAME_BITS-1];
                        link.shift_clk   <= 1'b1;
                        sent             <= 5'h00;
                        tick             <= HALF_PERIOD;
                        state            <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    // Half period of 4 mclk keeps far below 30 MHz
                    if (tick > 8'h01) begin
                        tick <= tick - 8'h01;
                    end else begin
                        tick <= HALF_PERIOD;
                        if (link.shift_clk) begin
                            link.shift_clk <= 1'b0;
                            sent           <= sent + 5'h01;
                        end else begin
                            link.shift_clk <= 1'b1;
                            word           <= {word[14:0], 1'b0};
                            link.serial_data <= word[FRAME_BITS-2];
                            if (sent == COUNT_LAST) begin
                                state <= ST_END;
                            end
                        end
                    end
                end
                ST_END: begin
                    link.frame_sel_n <= ~parked;
                    req_ready        <= 1'b1;
                    done             <= 1'b1;
                    state            <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : dac_host_end

//--- verification/dac_link_monitor.sv
`timescale 1ns/1ps
module dac_link_monitor (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic frame_sel_n,
    input wire logic shift_clk,
    input wire logic serial_data
);
    // ------------------------------------------------------------
    // Falling-edge counter of the current frame
    // ------------------------------------------------------------
    logic       clk_q;
    logic       fall;
    logic [4:0] fall_cnt;

    assign fall = clk_q & ~shift_clk;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            clk_q <= 1'b1;
        else
            clk_q <= shift_clk;
    end

    // Cleared while select is high, so a parked-low frame keeps its count
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            fall_cnt <= 5'h00;
        else if (frame_sel_n)
            fall_cnt <= 5'h00;
        else if (fall)
            fall_cnt <= fall_cnt + 5'h01;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_SCLK_IDLE: assert property (frame_sel_n |-> shift_clk)
        else $error("shift clock low while select high");
    AST_OPEN_CLK_HIGH: assert property ($fell(frame_sel_n) |-> shift_clk [*2])
        else $error("shift clock not high at frame open");
    AST_SCLK_LOW_TIME: assert property (fall |-> !shift_clk [*4])
        else $error("shift clock low phase too short");
    AST_SCLK_HIGH_TIME: assert property ($rose(shift_clk) && !frame_sel_n |-> shift_clk [*4])
        else $error("shift clock high phase too short");
    AST_DATA_HOLD: assert property (fall |-> $stable(serial_data))
        else $error("data moved at falling shift edge");
    AST_FRAME_LEN: assert property ($rose(frame_sel_n) |-> fall_cnt == 5'h10)
        else $error("frame closed without sixteen edges");
    AST_NO_EXTRA: assert property (fall && !frame_sel_n |-> fall_cnt < 5'h10)
        else $error("edge beyond sixteenth in frame");
    AST_IGNORED_ZERO: assert property (fall && !frame_sel_n && fall_cnt < 5'h02 |-> !serial_data)
        else $error("leading bits not zero");
    AST_FALL_IN_FRAME: assert property (fall |-> !frame_sel_n)
        else $error("shift edge outside frame");
endmodule : dac_link_monitor

//--- verification/serial_dac_load_interface_tb.sv
`timescale 1ns/1ps
module serial_dac_load_interface_tb;
    import dac_link_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, two links: host end, and a hand-driven rule breaker
    // ------------------------------------------------------------
    logic        mclk, nrst, req_valid, park_low, req_ready, done;
    logic        amp_enable, term_1k, term_100k, output_valid, sclk_q;
    logic [1:0]  req_mode;
    logic [11:0] req_code, dac_code, code_b;
    logic [15:0] wire_word;
    op_mode_t    op_mode, mode_b;
    int          fails, cmp_count, cycles;
    logic        load_a, load_b;
    int          loads_a, loads_b;
    logic [11:0] codes [4] = '{12'hFFF, 12'h800, 12'h001, 12'h7FF};

    dac_link_if link_a ();
    dac_link_if link_b ();
    dac_host_end dac_host_end_inst (.mclk(mclk), .nrst(nrst), .link(link_a), .req_valid(req_valid),
        .req_mode(req_mode), .req_code(req_code), .park_low(park_low), .req_ready(req_ready), .done(done));
    dac_load_end dac_load_end_inst (.mclk(mclk), .nrst(nrst), .link(link_a), .dac_code(dac_code),
        .op_mode(op_mode), .amp_enable(amp_enable), .term_1k(term_1k), .term_100k(term_100k),
        .output_valid(output_valid), .load_pulse(load_a));
    dac_load_end dac_load_end_inst_b (.mclk(mclk), .nrst(nrst), .link(link_b), .dac_code(code_b),
        .op_mode(mode_b), .amp_enable(), .term_1k(), .term_100k(), .output_valid(), .load_pulse(load_b));
    dac_link_monitor dac_link_monitor_inst (.mclk(mclk), .nrst(nrst), .frame_sel_n(link_a.frame_sel_n),
        .shift_clk(link_a.shift_clk), .serial_data(link_a.serial_data));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Word as seen on the wire, MSB arriving first
    always @(posedge mclk) begin
        sclk_q <= link_a.shift_clk;
        if (sclk_q && !link_a.shift_clk && !link_a.frame_sel_n)
            wire_word <= {wire_word[14:0], link_a.serial_data};
        if (load_a === 1'b1)
            loads_a++;
        if (load_b === 1'b1)
            loads_b++;
        cycles++;
        if (cycles == 10000) begin
            fails++;
            end_of_test();
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task dev(input logic [1:0] m, input logic [11:0] c);
        check(16'(dac_code), 16'(c));
        check(16'(op_mode), 16'(m));
        check({13'h0, amp_enable, term_1k, term_100k}, {13'h0, m == 2'h0, m == 2'h1, m == 2'h2});
    endtask : dev

    task send(input logic [1:0] m, input logic [11:0] c, input logic p);
        @(posedge mclk);
        #2;
        req_valid = 1'b1;
        req_mode = m;
        req_code = c;
        park_low = p;
        @(posedge mclk);
        #2;
        req_valid = 1'b0;
        check({15'h0, req_ready}, 16'h0000);
        for (int n = 0; n < 400; n++) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1)
                break;
        end
        check({15'h0, done}, 16'h0001);
        repeat (5) @(posedge mclk);
        #2;
        check(wire_word, {2'h0, m, c});
        check({15'h0, req_ready}, 16'h0001);
        dev(m, c);
    endtask : send

    // Released data shows the inverse so a stale bit cannot pass
    task bang(input logic [15:0] w, input int n, input logic sel_in, input logic sel_out);
        @(posedge mclk);
        #2;
        link_b.frame_sel_n = sel_in;
        for (int i = 0; i < n; i++) begin
            link_b.serial_data = w[15-i];
            repeat (4) @(posedge mclk);
            #2;
            link_b.shift_clk = 1'b0;
            repeat (4) @(posedge mclk);
            #2;
            link_b.shift_clk = 1'b1;
        end
        link_b.serial_data = ~w[16-n];
        repeat (4) @(posedge mclk);
        #2;
        link_b.frame_sel_n = sel_out;
        repeat (6) @(posedge mclk);
        #2;
    endtask : bang

    task end_of_test;
        if (fails == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    initial begin
        {nrst, req_valid, park_low, req_mode, req_code} = '0;
        {fails, cmp_count, cycles, loads_a, loads_b} = '0;
        link_b.frame_sel_n = 1'b1;
        link_b.shift_clk = 1'b1;
        link_b.serial_data = 1'b0;
        repeat (4) @(posedge mclk);
        #2;
        nrst = 1'b1;
        dev(2'h0, 12'h000);
        for (int m = 0; m < 4; m++) begin
            send(2'(m), codes[m], 1'(m));
            check({15'h0, output_valid}, {15'h0, m == 0});
        end
        send(2'h0, 12'h5A5, 1'b0);
        repeat (40) @(posedge mclk);
        #2;
        check({15'h0, output_valid}, 16'h0000);
        repeat (15) @(posedge mclk);
        #2;
        check({15'h0, output_valid}, 16'h0001);
        bang(16'h0ABC, 16, 1'b0, 1'b1);
        check(16'({2'(mode_b), code_b}), 16'h0ABC);
        bang(16'h3123, 10, 1'b0, 1'b1);
        check(16'({2'(mode_b), code_b}), 16'h0ABC);
        bang(16'h0456, 16, 1'b0, 1'b0);
        bang(16'h3FFF, 16, 1'b0, 1'b1);
        check(16'({2'(mode_b), code_b}), 16'h0456);
        bang(16'h2777, 16, 1'b1, 1'b1);
        check(16'({2'(mode_b), code_b}), 16'h0456);
        bang(16'hE321, 16, 1'b0, 1'b1);
        check(16'({2'(mode_b), code_b}), 16'h2321);
        check(16'(loads_a), 16'h0005);
        check(16'(loads_b), 16'h0003);
        end_of_test();
    end
endmodule : serial_dac_load_interface_tb
